// [logic/baeq_pkg.sv]
// Package for the bus activity event qualifier.
// Assumes a 32-bit APB register bus and one 200 MHz clock.
package baeq_pkg;
  // Register byte offsets
  localparam logic [7:0] BAEQ_SEL_OFF    = 8'h00;
  localparam logic [7:0] BAEQ_CTRL_OFF   = 8'h04;
  localparam logic [7:0] BAEQ_COUNT_OFF  = 8'h08;
  localparam logic [7:0] BAEQ_STAT_OFF   = 8'h0C;
  localparam logic [7:0] BAEQ_MASK_OFF   = 8'h10;
  localparam logic [7:0] BAEQ_LAST_OFF   = 8'h14;
  // Selection register fields
  localparam int BAEQ_EVSEL_LSB  = 25;
  localparam int BAEQ_EVSEL_W    = 7;
  localparam int BAEQ_EMASK_LSB  = 9;
  localparam int BAEQ_EMASK_W    = 16;
  // Event-mask bit positions, relative to the mask field
  localparam int BAEQ_M_SELF     = 3;
  localparam int BAEQ_M_OWNED    = 4;
  localparam int BAEQ_M_FOREIGN  = 5;
  localparam int BAEQ_M_KIND_LSB = 0;
  localparam int BAEQ_M_SIZE_LSB = 2;
  // Event select codes
  localparam logic [6:0] BAEQ_EV_DATA  = 7'h17;
  localparam logic [6:0] BAEQ_EV_ALLOC = 7'h05;
  // Control register fields
  localparam int BAEQ_C_ENABLE = 0;
  localparam int BAEQ_C_EDGE   = 1;
  // Status bits
  localparam int BAEQ_S_OVF    = 0;
  localparam int BAEQ_S_EXCL   = 1;
  localparam int BAEQ_NSTAT    = 2;
  // Reset values
  localparam logic [31:0] BAEQ_SEL_RST  = 32'h0000_0000;
  localparam logic [1:0]  BAEQ_CTRL_RST = 2'h0;
  // Request size codes
  localparam logic [1:0] BAEQ_SZ_ZERO  = 2'h0;
  localparam logic [1:0] BAEQ_SZ_ONE   = 2'h1;
  localparam logic [1:0] BAEQ_SZ_EIGHT = 2'h3;
  // Request kind codes
  typedef enum logic [1:0] {
    BAEQ_K_READ, BAEQ_K_READ_INV, BAEQ_K_WRITE, BAEQ_K_WRITEBACK
  } baeq_kind_t;
endpackage : baeq_pkg

// [logic/baeq_edge.sv]
// Rising-edge detector for one qualified event level.
// Assumes a synchronous level input.
`timescale 1ns/1ps
`default_nettype none
module baeq_edge (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // Event
  input  wire logic level,
  output logic      rise
);
  logic prev_q;
  logic prev_d;

  always_comb begin
    prev_d = level;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= prev_d;
    end
  end

  assign rise = level & ~prev_q;
endmodule : baeq_edge
`default_nettype wire

// [logic/baeq_alloc_match.sv]
// Queue allocation filter against the kind and size mask encodings.
// Assumes allocation attributes valid with the allocation strobe.
`timescale 1ns/1ps
`default_nettype none
module baeq_alloc_match
  import baeq_pkg::*;
(
  // Programmed encodings
  input  wire logic [1:0] want_kind,
  input  wire logic [1:0] want_size,
  // Observed allocation
  input  wire logic       alloc,
  input  wire logic [1:0] kind,
  input  wire logic [1:0] size,
  output logic            hit
);
  logic size_legal;

  always_comb begin
    size_legal = (size == BAEQ_SZ_ZERO) || (size == BAEQ_SZ_ONE) ||
                 (size == BAEQ_SZ_EIGHT);
    hit = alloc && size_legal && (kind == want_kind) &&
          (size == want_size);
  end
endmodule : baeq_alloc_match
`default_nettype wire

// [logic/baeq_top.sv]
// Bus activity event qualifier with its event counter behind APB.
// Assumes bus observation inputs synchronous to clk.
//
// Functional notes
// - Count self-drive data bus reservations.
// - Self-drive indication lasts two clocks, full lines.
// - Count reservations for data this processor samples.
// - Owned indication lasts two clocks, full lines.
// - Count reservations for data not sampled here.
// - Foreign indication two or four clocks.
// - Owned and foreign conditions are exclusive.
// - Count queue allocations matching the mask.
// - Mask field bits 24:9; low bits kind.
// - Mask bits 3:2 encode request size.
`timescale 1ns/1ps
`default_nettype none
module baeq_top
  import baeq_pkg::*;
#(
  parameter int CNT_W = 32
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Observed data bus reservations
  input  wire logic        reserve_self_drive,
  input  wire logic        reserve_owned_sample,
  input  wire logic        reserve_foreign,
  // Observed queue allocations
  input  wire logic        queue_allocation_event,
  input  wire logic [1:0]  alloc_kind,
  input  wire logic [1:0]  alloc_size,
  // Interrupt
  output logic             irq
);
  import baeq_pkg::*;

  // Refuse counter widths below 2 or wider than the 32-bit read path
  if (CNT_W < 2 || CNT_W > 32) begin : g_cnt_w_check
    $error("CNT_W must be 2 to 32");
  end

  logic [31:0]            sel_q, sel_d;
  logic [1:0]             ctrl_q, ctrl_d;
  logic [CNT_W-1:0]       cnt_q, cnt_d;
  logic [BAEQ_NSTAT-1:0]  stat_q, stat_d;
  logic [BAEQ_NSTAT-1:0]  mask_q, mask_d;
  logic [2:0]             last_q, last_d;
  logic [31:0]            prdata_q, prdata_d;
  logic                   pready_q, pready_d;
  logic                   pslverr_q, pslverr_d;
  logic                   irq_q, irq_d;

  logic [BAEQ_EVSEL_W-1:0] evsel;
  logic [BAEQ_EMASK_W-1:0] emask;
  logic                    data_level, alloc_hit, qual, qual_rise;
  logic                    inc, excl_err, wr_acc, rd_acc, mapped;

  assign evsel = sel_q[BAEQ_EVSEL_LSB +: BAEQ_EVSEL_W];
  assign emask = sel_q[BAEQ_EMASK_LSB +: BAEQ_EMASK_W];

  baeq_alloc_match u_match (
    .want_kind (emask[BAEQ_M_KIND_LSB +: 2]),
    .want_size (emask[BAEQ_M_SIZE_LSB +: 2]),
    .alloc     (queue_allocation_event),
    .kind      (alloc_kind),
    .size      (alloc_size),
    .hit       (alloc_hit)
  );

  baeq_edge u_edge (
    .clk   (clk),
    .reset (reset),
    .level (qual),
    .rise  (qual_rise)
  );

  // Event qualification
  always_comb begin
    data_level = (emask[BAEQ_M_SELF]    & reserve_self_drive) |
                 (emask[BAEQ_M_OWNED]   & reserve_owned_sample) |
                 (emask[BAEQ_M_FOREIGN] & reserve_foreign);
    // Owned and foreign together is a bus fault; neither is counted
    excl_err = reserve_owned_sample & reserve_foreign;
    if (excl_err) begin
      data_level = emask[BAEQ_M_SELF] & reserve_self_drive;
    end
    case (evsel)
      BAEQ_EV_DATA:  qual = data_level;
      BAEQ_EV_ALLOC: qual = alloc_hit;
      default:       qual = 1'b0;
    endcase
    // Multi-clock indications count once in edge mode
    inc = ctrl_q[BAEQ_C_ENABLE] &
          (ctrl_q[BAEQ_C_EDGE] ? qual_rise : qual);
  end

  assign wr_acc = psel & penable & pwrite & ~pready_q;
  assign rd_acc = psel & penable & ~pwrite & ~pready_q;

  // Register file and counter
  always_comb begin
    sel_d    = sel_q;
    ctrl_d   = ctrl_q;
    cnt_d    = cnt_q;
    mask_d   = mask_q;
    stat_d   = stat_q;
    last_d   = {reserve_foreign, reserve_owned_sample, reserve_self_drive};
    mapped   = 1'b1;
    if (wr_acc) begin
      case (paddr)
        BAEQ_SEL_OFF:   sel_d  = pwdata;
        BAEQ_CTRL_OFF:  ctrl_d = pwdata[1:0];
        BAEQ_COUNT_OFF: cnt_d  = pwdata[CNT_W-1:0];
        BAEQ_STAT_OFF:  stat_d = stat_q & ~pwdata[BAEQ_NSTAT-1:0];
        BAEQ_MASK_OFF:  mask_d = pwdata[BAEQ_NSTAT-1:0];
        BAEQ_LAST_OFF:  mapped = 1'b1;
        default:        mapped = 1'b0;
      endcase
    end
    if (inc && !(wr_acc && paddr == BAEQ_COUNT_OFF)) begin
      cnt_d = cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
      if (&cnt_q) begin
        stat_d[BAEQ_S_OVF] = 1'b1;
      end
    end
    // Set wins over clear
    if (excl_err) begin
      stat_d[BAEQ_S_EXCL] = 1'b1;
    end
  end

  // APB answer, one wait state
  always_comb begin
    pready_d  = psel & penable & ~pready_q;
    pslverr_d = 1'b0;
    prdata_d  = 32'h0000_0000;
    if (rd_acc) begin
      case (paddr)
        BAEQ_SEL_OFF:   prdata_d = sel_q;
        BAEQ_CTRL_OFF:  prdata_d = {30'h0000_0000, ctrl_q};
        BAEQ_COUNT_OFF: prdata_d = 32'(cnt_q);
        BAEQ_STAT_OFF:  prdata_d = {30'h0000_0000, stat_q};
        BAEQ_MASK_OFF:  prdata_d = {30'h0000_0000, mask_q};
        BAEQ_LAST_OFF:  prdata_d = {29'h0000_0000, last_q};
        default:        pslverr_d = 1'b1;
      endcase
    end
    if (wr_acc && !mapped) begin
      pslverr_d = 1'b1;
    end
    irq_d = |(stat_d & mask_d);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      sel_q     <= BAEQ_SEL_RST;
      ctrl_q    <= BAEQ_CTRL_RST;
      cnt_q     <= '0;
      stat_q    <= '0;
      mask_q    <= '0;
      last_q    <= 3'h0;
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      irq_q     <= 1'b0;
    end else begin
      sel_q     <= sel_d;
      ctrl_q    <= ctrl_d;
      cnt_q     <= cnt_d;
      stat_q    <= stat_d;
      mask_q    <= mask_d;
      last_q    <= last_d;
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      irq_q     <= irq_d;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign irq     = irq_q;

  // Checks
  logic active_q;
  logic [CNT_W-1:0] cnt_p;
  always_ff @(posedge clk) begin
    active_q <= ~reset;
    cnt_p    <= cnt_q;
  end

  property p_self_count;
    @(posedge clk) disable iff (reset)
    (evsel == BAEQ_EV_DATA && ctrl_q == 2'h1 && emask[BAEQ_M_SELF] &&
     reserve_self_drive && !wr_acc) |=> (cnt_q == $past(cnt_q) + 1'b1);
  endproperty
  a_self_count: assert property (p_self_count)
    else $error("self-drive reservation not counted");

  property p_edge_once;
    @(posedge clk) disable iff (reset)
    (ctrl_q == 2'h3 && qual && $past(qual) && active_q && !wr_acc &&
     $stable(ctrl_q)) |=> (cnt_q == $past(cnt_q));
  endproperty
  a_edge_once: assert property (p_edge_once)
    else $error("held event counted twice in edge mode");

  property p_two_clock_once;
    @(posedge clk) disable iff (reset)
    (ctrl_q == 2'h3 && evsel == BAEQ_EV_DATA && emask[BAEQ_M_SELF] &&
     !qual && !wr_acc ##1 (reserve_self_drive && !wr_acc) [*2])
    |=> (cnt_q == $past(cnt_q, 2) + 1'b1);
  endproperty
  a_two_clock_once: assert property (p_two_clock_once)
    else $error("two-clock indication miscounted");

  property p_owned_count;
    @(posedge clk) disable iff (reset)
    (evsel == BAEQ_EV_DATA && ctrl_q == 2'h1 && emask == 16'h0010 &&
     reserve_owned_sample && !reserve_foreign && !wr_acc)
    |=> (cnt_q == $past(cnt_q) + 1'b1);
  endproperty
  a_owned_count: assert property (p_owned_count)
    else $error("owned reservation not counted");

  property p_foreign_count;
    @(posedge clk) disable iff (reset)
    (evsel == BAEQ_EV_DATA && ctrl_q == 2'h1 && emask == 16'h0020 &&
     reserve_foreign && !reserve_owned_sample && !wr_acc)
    |=> (cnt_q == $past(cnt_q) + 1'b1);
  endproperty
  a_foreign_count: assert property (p_foreign_count)
    else $error("foreign reservation not counted");

  property p_excl;
    @(posedge clk) disable iff (reset)
    (reserve_owned_sample && reserve_foreign) |=> stat_q[BAEQ_S_EXCL];
  endproperty
  a_excl: assert property (p_excl)
    else $error("exclusive violation not flagged");

  property p_alloc;
    @(posedge clk) disable iff (reset)
    (evsel == BAEQ_EV_ALLOC && ctrl_q == 2'h1 && !wr_acc &&
     queue_allocation_event && alloc_kind == emask[1:0] &&
     alloc_size == emask[3:2] && alloc_size != 2'h2)
    |=> (cnt_q == $past(cnt_q) + 1'b1);
  endproperty
  a_alloc: assert property (p_alloc)
    else $error("matching allocation not counted");

  property p_alloc_miss;
    @(posedge clk) disable iff (reset)
    (evsel == BAEQ_EV_ALLOC && !wr_acc && queue_allocation_event &&
     alloc_kind != emask[1:0]) |=> (cnt_q == cnt_p);
  endproperty
  a_alloc_miss: assert property (p_alloc_miss)
    else $error("non-matching allocation counted");

  property p_ready_pulse;
    @(posedge clk) disable iff (reset)
    pready_q |=> !pready_q;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("pready held longer than one cycle");

  property p_ready_answer;
    @(posedge clk) disable iff (reset)
    (psel && penable && !pready_q) |=> pready_q;
  endproperty
  a_ready_answer: assert property (p_ready_answer)
    else $error("access phase not answered after one wait state");

  property p_err_with_ready;
    @(posedge clk) disable iff (reset)
    pslverr_q |-> pready_q;
  endproperty
  a_err_with_ready: assert property (p_err_with_ready)
    else $error("pslverr raised without pready");

  property p_irq_level;
    @(posedge clk) disable iff (reset)
    active_q |-> (irq_q == |(stat_q & mask_q));
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt level disagrees with status and mask");

  property p_ovf_set;
    @(posedge clk) disable iff (reset)
    (inc && (&cnt_q) && !(wr_acc && paddr == BAEQ_COUNT_OFF))
    |=> stat_q[BAEQ_S_OVF];
  endproperty
  a_ovf_set: assert property (p_ovf_set)
    else $error("counter wrap did not set overflow");

  property p_edge_rise;
    @(posedge clk) disable iff (reset)
    (ctrl_q == 2'h3 && qual && active_q && !$past(qual) && !wr_acc)
    |=> (cnt_q == $past(cnt_q) + 1'b1);
  endproperty
  a_edge_rise: assert property (p_edge_rise)
    else $error("rising event not counted in edge mode");

  property p_excl_none;
    @(posedge clk) disable iff (reset)
    (evsel == BAEQ_EV_DATA && ctrl_q == 2'h1 && !wr_acc &&
     reserve_owned_sample && reserve_foreign &&
     !(emask[BAEQ_M_SELF] && reserve_self_drive))
    |=> (cnt_q == $past(cnt_q));
  endproperty
  a_excl_none: assert property (p_excl_none)
    else $error("conflicting reservations were counted");

  property p_disabled;
    @(posedge clk) disable iff (reset)
    (!ctrl_q[BAEQ_C_ENABLE] && !wr_acc) |=> (cnt_q == $past(cnt_q));
  endproperty
  a_disabled: assert property (p_disabled)
    else $error("counter moved while disabled");

  property p_size_two;
    @(posedge clk) disable iff (reset)
    (evsel == BAEQ_EV_ALLOC && ctrl_q == 2'h1 && !wr_acc &&
     queue_allocation_event && alloc_size == 2'h2)
    |=> (cnt_q == $past(cnt_q));
  endproperty
  a_size_two: assert property (p_size_two)
    else $error("allocation with unused size code counted");

  property p_w1c;
    @(posedge clk) disable iff (reset)
    (wr_acc && paddr == BAEQ_STAT_OFF && pwdata[BAEQ_S_EXCL] && !excl_err)
    |=> !stat_q[BAEQ_S_EXCL];
  endproperty
  a_w1c: assert property (p_w1c)
    else $error("status bit not cleared by writing one");
endmodule : baeq_top
`default_nettype wire

// [sim/baeq_bus_agent.sv]
// Far-side bus agents: reservation levels and queue allocations.
// Assumes the bench calls its tasks; drives just after rising edges.
`timescale 1ns/1ps
`default_nettype none
module baeq_bus_agent (
  // Clock
  input  wire logic clk,
  // Reservations
  output logic      rsv_self,
  output logic      rsv_owned,
  output logic      rsv_foreign,
  // Allocations
  output logic       alloc,
  output logic [1:0] kind,
  output logic [1:0] size
);
  initial begin
    {rsv_foreign, rsv_owned, rsv_self} = 3'h0;
    alloc = 1'b0;
    kind  = 2'h0;
    size  = 2'h0;
  end
  // Level of n clocks, repeated one clock apart as under a stall
  task automatic reserve(input logic [2:0] w, input int n, input int reps);
    repeat (reps) begin
      repeat (n) begin
        @(posedge clk);
        {rsv_foreign, rsv_owned, rsv_self} <= w;
      end
      @(posedge clk);
      {rsv_foreign, rsv_owned, rsv_self} <= 3'h0;
    end
  endtask : reserve
  // One allocation; attributes scrambled once it is over
  task automatic allocate(input logic [1:0] k, input logic [1:0] s);
    @(posedge clk);
    alloc <= 1'b1;
    kind  <= k;
    size  <= s;
    @(posedge clk);
    alloc <= 1'b0;
    kind  <= ~k;
    size  <= ~s;
  endtask : allocate
endmodule : baeq_bus_agent
`default_nettype wire

// [sim/baeq_top_tb.sv]
// Self-checking bench for the bus activity event qualifier.
// Assumes baeq_top with one APB wait state and baeq_bus_agent.
`timescale 1ns/1ps
`default_nettype none
module baeq_top_tb;
  import baeq_pkg::*;
  logic        clk;
  logic        reset;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        r_self;
  logic        r_own;
  logic        r_for;
  logic        q_ev;
  logic [1:0]  q_kind;
  logic [1:0]  q_size;
  logic        irq;
  logic [31:0] rd;
  logic        err;
  int          fail_count;
  int          n_compared;
  logic [15:0] dm [7] = '{16'h8, 16'h8, 16'h10, 16'h10, 16'h20, 16'h20, 16'h8};
  logic [2:0]  dw [7] = '{3'h1, 3'h1, 3'h2, 3'h2, 3'h4, 3'h4, 3'h2};
  logic [1:0]  dc [7] = '{2'h1, 2'h3, 2'h3, 2'h1, 2'h1, 2'h1, 2'h1};
  int          dn [7] = '{2, 2, 2, 2, 4, 2, 2};
  int          dr [7] = '{2, 2, 2, 2, 1, 1, 1};
  logic [31:0] de [7] = '{32'h4, 32'h2, 32'h2, 32'h4, 32'h4, 32'h2, 32'h0};
  logic [1:0]  sz [3] = '{BAEQ_SZ_ZERO, BAEQ_SZ_ONE, BAEQ_SZ_EIGHT};

  baeq_top u_baeq_top (.clk(clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .reserve_self_drive(r_self), .reserve_owned_sample(r_own),
    .reserve_foreign(r_for), .queue_allocation_event(q_ev),
    .alloc_kind(q_kind), .alloc_size(q_size), .irq(irq));
  baeq_bus_agent u_baeq_bus_agent (.clk(clk), .rsv_self(r_self),
    .rsv_owned(r_own), .rsv_foreign(r_for), .alloc(q_ev), .kind(q_kind),
    .size(q_size));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic results();
    $display("Compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      fail_count++;
      $display("[ERR] %0t no pready", $time);
      results();
    end
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
    chk({31'h0, err}, 32'h0);
  endtask : rdchk

  task automatic setup(input logic [31:0] sel, input logic [1:0] ctrl);
    apb(1'b1, BAEQ_SEL_OFF, sel);
    apb(1'b1, BAEQ_CTRL_OFF, {30'h0, ctrl});
    apb(1'b1, BAEQ_COUNT_OFF, 32'h0);
  endtask : setup

  function automatic logic [31:0] selv(input logic [6:0] ev,
                                       input logic [15:0] m);
    return {ev, m, 9'h000};
  endfunction : selv

  initial begin
    fail_count = 0;
    n_compared = 0;
    reset   = 1'b1;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    rdchk(BAEQ_SEL_OFF, BAEQ_SEL_RST);
    rdchk(BAEQ_CTRL_OFF, {30'h0, BAEQ_CTRL_RST});
    rdchk(BAEQ_COUNT_OFF, 32'h0);
    apb(1'b0, 8'h18, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("Test reset and unmapped done");
    for (int i = 0; i < 7; i++) begin
      setup(selv(BAEQ_EV_DATA, dm[i]), dc[i]);
      u_baeq_bus_agent.reserve(dw[i], dn[i], dr[i]);
      repeat (2) @(posedge clk);
      rdchk(BAEQ_COUNT_OFF, de[i]);
    end
    $display("Test reservations done");
    setup(selv(BAEQ_EV_DATA, 16'h0030), 2'h1);
    u_baeq_bus_agent.reserve(3'h6, 2, 1);
    repeat (2) @(posedge clk);
    rdchk(BAEQ_COUNT_OFF, 32'h0);
    rdchk(BAEQ_STAT_OFF, 32'h2);
    @(negedge clk);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, BAEQ_MASK_OFF, 32'h2);
    repeat (2) @(negedge clk);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, BAEQ_STAT_OFF, 32'h2);
    repeat (2) @(negedge clk);
    chk({31'h0, irq}, 32'h0);
    rdchk(BAEQ_STAT_OFF, 32'h0);
    $display("Test exclusive and interrupt done");
    setup(selv(BAEQ_EV_DATA, 16'h0008), 2'h1);
    apb(1'b1, BAEQ_COUNT_OFF, 32'hFFFF_FFFF);
    u_baeq_bus_agent.reserve(3'h1, 1, 1);
    repeat (2) @(posedge clk);
    rdchk(BAEQ_COUNT_OFF, 32'h0);
    rdchk(BAEQ_STAT_OFF, 32'h1);
    fork
      u_baeq_bus_agent.reserve(3'h1, 8, 1);
      begin
        repeat (2) @(posedge clk);
        rdchk(BAEQ_LAST_OFF, 32'h1);
      end
    join
    $display("Test overflow and last inputs done");
    for (int k = 0; k < 4; k++) begin
      setup(selv(BAEQ_EV_ALLOC, {12'h0, BAEQ_SZ_EIGHT, 2'(k)}),
            2'h1);
      for (int j = 0; j < 4; j++) begin
        u_baeq_bus_agent.allocate(2'(j), BAEQ_SZ_EIGHT);
      end
      u_baeq_bus_agent.allocate(2'(k), BAEQ_SZ_ONE);
      repeat (2) @(posedge clk);
      rdchk(BAEQ_COUNT_OFF, 32'h1);
    end
    for (int s = 0; s < 3; s++) begin
      setup(selv(BAEQ_EV_ALLOC, {12'h0, sz[s], 2'h0}), 2'h1);
      for (int j = 0; j < 4; j++) begin
        u_baeq_bus_agent.allocate(2'h0, 2'(j));
      end
      repeat (2) @(posedge clk);
      rdchk(BAEQ_COUNT_OFF, 32'h1);
    end
    $display("Test allocations done");
    results();
  end
endmodule : baeq_top_tb
`default_nettype wire
